// File: hdl/dagu_pkg.sv
// Purpose: Shared types and constants for the dual address generation unit
// Assumes: 24-bit addresses, four register triplets per half
// Notes: Modifier decode values are plain defaults, overridable by parameter, except that dagu_arith reads MOD_MULTI_MASK from here
package dagu_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int NUM_TRIP = 4;
  localparam int SEL_W = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
  localparam logic [ADDR_W-1:0] OFS_RST = 24'h00_0000;
  localparam logic [ADDR_W-1:0] MOD_RST = 24'hFF_FFFF;

  // ****************************************
  // Modifier decode table defaults
  // ****************************************
  localparam logic [ADDR_W-1:0] MOD_LINEAR = 24'hFF_FFFF;
  localparam logic [ADDR_W-1:0] MOD_REVERSE = 24'h00_0000;
  localparam logic [ADDR_W-1:0] MOD_MULTI_BASE = 24'h00_8000;
  localparam logic [ADDR_W-1:0] MOD_MULTI_MASK = 24'hFF_8000;
  localparam logic [ADDR_W-1:0] MOD_MODULO_MASK = 24'hFF_8000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ARITH_LINEAR,
    ARITH_MODULO,
    ARITH_MULTI,
    ARITH_REVERSE
  } dagu_arith_t;

  typedef enum logic [1:0] {
    WR_ADDR,
    WR_OFS,
    WR_MOD
  } dagu_wsel_t;

  // Update request from the instruction decoder for one half
  typedef struct packed {
    logic upd;
    logic [SEL_W-1:0] sel;
  } dagu_upd_t;

  // Register load request from the data bus for one half
  typedef struct packed {
    logic wr;
    dagu_wsel_t kind;
    logic [SEL_W-1:0] sel;
    logic [ADDR_W-1:0] data;
  } dagu_wr_t;

endpackage

// File: hdl/dagu_arith.sv
// Purpose: Combinational address arithmetic of one half
// Assumes: Modulo value M-1 sits in the low bits of the modifier
// Notes: Pure logic, no state
`timescale 1ns/1ns
module dagu_arith #(
  parameter int W = dagu_pkg::ADDR_W
) (
  input wire logic [W-1:0] addr,
  input wire logic [W-1:0] ofs,
  input wire logic [W-1:0] modv,
  input wire dagu_pkg::dagu_arith_t kind,
  output logic [W-1:0] result
);

  logic [W-1:0] ofs_sum;
  logic [W-1:0] addr_rev;
  logic [W-1:0] ofs_rev;
  logic [W-1:0] rev_raw;
  logic [W-1:0] rev_sum;
  logic [W-1:0] mod_size;
  logic [W-1:0] mod_mask;
  logic [W-1:0] base;
  logic [W-1:0] top;
  logic [W-1:0] wrap_up;
  logic [W-1:0] wrap_dn;
  logic [W-1:0] mod_sum;
  logic [W-1:0] multi_sum;
  logic [W-1:0] low_mask;
  logic ofs_neg;

  // Offset adder
  assign ofs_sum = addr + ofs;

  // Reverse-carry adder on the same inputs, carry runs high to low
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_rev
      assign addr_rev[i] = addr[W-1-i];
      assign ofs_rev[i] = ofs[W-1-i];
      assign rev_sum[i] = rev_raw[W-1-i];
    end
  endgenerate
  assign rev_raw = addr_rev + ofs_rev;

  // Modulo adder: wrap the offset sum by the modulus
  assign mod_size = modv + W'(1);
  assign mod_mask = {1'b0, modv[W-1:1]} | modv;
  assign ofs_neg = ofs[W-1];
  assign base = addr & ~(mod_mask | (mod_mask >> 1) | (mod_mask >> 2) | (mod_mask >> 4)
                | (mod_mask >> 8) | (mod_mask >> 16));
  assign top = base + modv;
  assign wrap_up = ofs_sum - mod_size;
  assign wrap_dn = ofs_sum + mod_size;
  assign mod_sum = (!ofs_neg && (ofs_sum > top)) ? wrap_up :
                   (ofs_neg && (ofs_sum < base)) ? wrap_dn : ofs_sum;

  // Multiple wrap-around: power-of-two block, offset sum masked into it
  assign low_mask = modv & ~dagu_pkg::MOD_MULTI_MASK;
  assign multi_sum = (addr & ~low_mask) | (ofs_sum & low_mask);

  // One of the adder results leaves the half
  always_comb begin
    unique case (kind)
      dagu_pkg::ARITH_LINEAR: result = ofs_sum;
      dagu_pkg::ARITH_MODULO: result = mod_sum;
      dagu_pkg::ARITH_MULTI: result = multi_sum;
      dagu_pkg::ARITH_REVERSE: result = rev_sum;
    endcase
  end

endmodule

// File: hdl/dagu_top.sv
// Purpose: Dual address generation unit, two identical halves
// Assumes: Decoder issues at most one update per half per cycle
// Notes: Addresses out are registered; update lands one edge after request
//
// Operation
// - Linear, modulo, multi-wrap and reverse-carry arithmetic
// - Address math in parallel, no extra cycles
// - Two identical independent halves
// - Four address, offset, modifier triplets per half
// - 24-bit offset adder adds address and offset
// - Modulo adder wraps offset sum by modifier
// - Reverse-carry adder shares offset adder inputs
// - Select one adder result per update
// - At most one address update per half
// - Paired modifier decoded to choose arithmetic
// - All buses 24 bits wide
`timescale 1ns/1ns
module dagu_top #(
  parameter logic [23:0] MOD_LINEAR = dagu_pkg::MOD_LINEAR,
  parameter logic [23:0] MOD_REVERSE = dagu_pkg::MOD_REVERSE,
  parameter logic [23:0] MOD_MULTI_BASE = dagu_pkg::MOD_MULTI_BASE,
  parameter logic [23:0] MOD_MULTI_MASK = dagu_pkg::MOD_MULTI_MASK,
  parameter logic [23:0] MOD_MODULO_MASK = dagu_pkg::MOD_MODULO_MASK
) (
  input wire logic clk,
  input wire logic reset,
  input wire dagu_pkg::dagu_upd_t upd_x,
  input wire dagu_pkg::dagu_upd_t upd_y,
  input wire dagu_pkg::dagu_wr_t wr_x,
  input wire dagu_pkg::dagu_wr_t wr_y,
  output logic [dagu_pkg::ADDR_W-1:0] xab_q,
  output logic [dagu_pkg::ADDR_W-1:0] yab_q,
  output logic xab_valid_q,
  output logic yab_valid_q
);

  localparam int W = dagu_pkg::ADDR_W;
  localparam int N = dagu_pkg::NUM_TRIP;
  localparam int SW = dagu_pkg::SEL_W;

  // ****************************************
  // Two identical halves
  // ****************************************
  dagu_pkg::dagu_upd_t upd [2];
  dagu_pkg::dagu_wr_t wr [2];
  logic [W-1:0] bus_q [2];
  logic bus_v_q [2];

  assign upd[0] = upd_x;
  assign upd[1] = upd_y;
  assign wr[0] = wr_x;
  assign wr[1] = wr_y;
  assign xab_q = bus_q[0];
  assign yab_q = bus_q[1];
  assign xab_valid_q = bus_v_q[0];
  assign yab_valid_q = bus_v_q[1];

  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_half
      logic [W-1:0] addr_q [N];
      logic [W-1:0] ofs_q [N];
      logic [W-1:0] mod_q [N];
      logic [W-1:0] cur_addr;
      logic [W-1:0] cur_ofs;
      logic [W-1:0] cur_mod;
      logic [W-1:0] new_addr;
      logic is_lin;
      logic is_rev;
      logic is_multi;
      dagu_pkg::dagu_arith_t kind;
      logic [W-1:0] bus_d;

      assign cur_addr = addr_q[upd[h].sel];
      assign cur_ofs = ofs_q[upd[h].sel];
      assign cur_mod = mod_q[upd[h].sel];

      // Modifier decode table
      assign is_lin = (cur_mod == MOD_LINEAR);
      assign is_rev = (cur_mod == MOD_REVERSE);
      assign is_multi = ((cur_mod & MOD_MULTI_MASK) == MOD_MULTI_BASE);
      assign kind = is_lin ? dagu_pkg::ARITH_LINEAR :
                    is_rev ? dagu_pkg::ARITH_REVERSE :
                    is_multi ? dagu_pkg::ARITH_MULTI :
                    dagu_pkg::ARITH_MODULO;

      dagu_arith #(
        .W(W)
      ) u_arith (
        .addr(cur_addr),
        .ofs(cur_ofs),
        .modv(cur_mod & ~MOD_MODULO_MASK),
        .kind(kind),
        .result(new_addr)
      );

      // Bus carries pre-update address in the same cycle as the update
      assign bus_d = upd[h].upd ? cur_addr : bus_q[h];

      always_ff @(posedge clk) begin
        if (reset) begin
          bus_q[h] <= dagu_pkg::ADDR_RST;
          bus_v_q[h] <= 1'b0;
        end else begin
          bus_q[h] <= bus_d;
          bus_v_q[h] <= upd[h].upd;
        end
      end

      genvar r;
      for (r = 0; r < N; r++) begin : g_trip
        localparam logic [SW-1:0] IDX = SW'(r);
        logic hit_upd;
        logic hit_wr;
        assign hit_upd = upd[h].upd && (upd[h].sel == IDX);
        assign hit_wr = wr[h].wr && (wr[h].sel == IDX);

        always_ff @(posedge clk) begin
          if (reset) begin
            addr_q[r] <= dagu_pkg::ADDR_RST;
          end else if (hit_wr && wr[h].kind == dagu_pkg::WR_ADDR) begin
            addr_q[r] <= wr[h].data;
          end else if (hit_upd) begin
            addr_q[r] <= new_addr;
          end
        end

        always_ff @(posedge clk) begin
          if (reset) begin
            ofs_q[r] <= dagu_pkg::OFS_RST;
            mod_q[r] <= dagu_pkg::MOD_RST;
          end else if (hit_wr && wr[h].kind == dagu_pkg::WR_OFS) begin
            ofs_q[r] <= wr[h].data;
          end else if (hit_wr && wr[h].kind == dagu_pkg::WR_MOD) begin
            mod_q[r] <= wr[h].data;
          end
        end
      end
    end
  endgenerate

endmodule

// File: verification/dagu_top_asserts.sv
// Purpose: Port checks of dagu_top
// Assumes: One clock, sync reset
// Notes: Bound below
`timescale 1ns/1ns
module dagu_top_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire dagu_pkg::dagu_upd_t upd_x,
  input wire dagu_pkg::dagu_upd_t upd_y,
  input wire dagu_pkg::dagu_wr_t wr_x,
  input wire dagu_pkg::dagu_wr_t wr_y,
  input wire logic [23:0] xab_q,
  input wire logic [23:0] yab_q,
  input wire logic xab_valid_q,
  input wire logic yab_valid_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_x_valid: assert property (upd_x.upd |=> xab_valid_q) else $error("x valid");
  a_y_valid: assert property (upd_y.upd |=> yab_valid_q) else $error("y valid");
  a_x_quiet: assert property (!upd_x.upd |=> !xab_valid_q) else $error("x stray");
  a_y_quiet: assert property (!upd_y.upd |=> !yab_valid_q) else $error("y stray");
  a_x_hold: assert property (!upd_x.upd |=> $stable(xab_q)) else $error("x moved");
  a_y_hold: assert property (!upd_y.upd |=> $stable(yab_q)) else $error("y moved");
  a_x_burst: assert property (upd_x.upd[*2] |-> xab_valid_q[*2]) else $error("x run");
  a_y_burst: assert property (upd_y.upd[*2] |-> yab_valid_q[*2]) else $error("y run");
  a_y_load_wins: assert property ((upd_y.upd && wr_y.wr && wr_y.kind == dagu_pkg::WR_ADDR
    && wr_y.sel == upd_y.sel) ##1 (upd_y.upd && !wr_y.wr && upd_y.sel == $past(upd_y.sel))
    |=> yab_q == $past(wr_y.data, 2)) else $error("y load lost");
  c_x_run: cover property (upd_x.upd[*3]);
  c_y_run: cover property (upd_y.upd[*3]);
  c_mod_ld: cover property (wr_y.wr && wr_y.kind == dagu_pkg::WR_MOD);
  c_collide: cover property (upd_y.upd && wr_y.wr && wr_y.kind == dagu_pkg::WR_ADDR
    && wr_y.sel == upd_y.sel);
endmodule

bind dagu_top dagu_top_asserts chk (.clk(clk), .reset(reset), .upd_x(upd_x), .upd_y(upd_y),
  .wr_x(wr_x), .wr_y(wr_y), .xab_q(xab_q), .yab_q(yab_q), .xab_valid_q(xab_valid_q),
  .yab_valid_q(yab_valid_q));

// File: verification/dagu_mem_model.sv
// Purpose: Memory side of the address buses
// Assumes: Address valid for one cycle
// Notes: Queues hold every bus address seen while its valid is high
`timescale 1ns/1ns
module dagu_mem_model (
  input wire logic clk,
  input wire logic [23:0] xab_q,
  input wire logic [23:0] yab_q,
  input wire logic xv,
  input wire logic yv
);
  logic [23:0] qx[$];
  logic [23:0] qy[$];
  always @(posedge clk) begin
    if (xv === 1'b1) qx.push_back(xab_q);
    if (yv === 1'b1) qy.push_back(yab_q);
  end
endmodule

// File: verification/test_dual_address_generation_unit.sv
// Purpose: Bench of the dual address unit
// Assumes: Requests driven 1 ns after the edge
// Notes: Memory model records bus addresses
`timescale 1ns/1ns
module test_dual_address_generation_unit;
  logic clk;
  logic reset;
  dagu_pkg::dagu_upd_t upd_x, upd_y;
  dagu_pkg::dagu_wr_t wr_x, wr_y;
  logic [23:0] xab_q, yab_q;
  logic xv, yv;
  int failures = 0;
  int comparisons = 0;
  dagu_top dut (.clk(clk), .reset(reset), .upd_x(upd_x), .upd_y(upd_y), .wr_x(wr_x),
    .wr_y(wr_y), .xab_q(xab_q), .yab_q(yab_q), .xab_valid_q(xv), .yab_valid_q(yv));
  dagu_mem_model mem (.clk(clk), .xab_q(xab_q), .yab_q(yab_q), .xv(xv), .yv(yv));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cmp(input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR addr expected %h seen %h", e, g);
    end
  endtask
  task automatic chk(input bit y, input logic [23:0] e);
    logic [23:0] g;
    g = 'x;
    if (y && mem.qy.size() > 0) g = mem.qy.pop_front();
    if (!y && mem.qx.size() > 0) g = mem.qx.pop_front();
    cmp(e, g);
  endtask
  // Loads address, offset, modifier on consecutive edges
  task automatic prog(input bit y, input logic [1:0] s, input logic [23:0] m, a, o);
    dagu_pkg::dagu_wr_t w;
    for (int i = 0; i < 3; i++) begin
      w = {1'b1, dagu_pkg::dagu_wsel_t'(i), s, (i == 0) ? a : ((i == 1) ? o : m)};
      @(posedge clk);
      #1;
      wr_x = y ? '0 : w;
      wr_y = y ? w : '0;
    end
    @(posedge clk);
    #1;
    wr_x = '0;
    wr_y = '0;
  endtask
  task automatic step(input bit y, input logic [1:0] s, input int n);
    @(posedge clk);
    #1;
    if (y) upd_y = {1'b1, s};
    else upd_x = {1'b1, s};
    repeat (n) @(posedge clk);
    #1;
    upd_x = '0;
    upd_y = '0;
    @(posedge clk);
    #1;
  endtask
  task automatic t_linear;
    prog(0, 2'h1, 24'hFF_FFFF, 24'h00_0010, 24'h00_0003);
    step(0, 2'h1, 3);
    chk(0, 24'h00_0010);
    chk(0, 24'h00_0013);
    chk(0, 24'h00_0016);
    cmp(24'h00_0000, 24'(mem.qy.size()));
  endtask
  task automatic t_modulo;
    prog(0, 2'h0, 24'h00_0004, 24'h00_0100, 24'h00_0001);
    step(0, 2'h0, 6);
    for (int i = 0; i < 6; i++) begin
      chk(0, 24'h00_0100 + 24'(i % 5));
    end
    step(0, 2'h1, 1);
    chk(0, 24'h00_0019);
  endtask
  task automatic t_reverse;
    prog(1, 2'h2, 24'h00_0000, 24'h00_0000, 24'h80_0000);
    step(1, 2'h2, 3);
    chk(1, 24'h00_0000);
    chk(1, 24'h80_0000);
    chk(1, 24'h40_0000);
  endtask
  task automatic t_multi;
    prog(1, 2'h3, 24'h00_8007, 24'h00_0006, 24'h00_0003);
    step(1, 2'h3, 3);
    chk(1, 24'h00_0006);
    chk(1, 24'h00_0001);
    chk(1, 24'h00_0004);
  endtask
  // Modulo buffer walked downwards, wraps from base to top
  task automatic t_modulo_down;
    prog(0, 2'h2, 24'h00_0004, 24'h00_0100, 24'hFF_FFFF);
    step(0, 2'h2, 3);
    chk(0, 24'h00_0100);
    chk(0, 24'h00_0104);
    chk(0, 24'h00_0103);
  endtask
  // Address load and update of one triplet in one cycle: load wins
  task automatic t_collide;
    prog(1, 2'h0, 24'hFF_FFFF, 24'h00_0020, 24'h00_0001);
    @(posedge clk);
    #1;
    upd_y = {1'b1, 2'h0};
    wr_y = {1'b1, dagu_pkg::WR_ADDR, 2'h0, 24'h00_0050};
    @(posedge clk);
    #1;
    wr_y = '0;
    @(posedge clk);
    #1;
    upd_y = '0;
    @(posedge clk);
    #1;
    chk(1, 24'h00_0020);
    chk(1, 24'h00_0050);
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    reset = 1'b1;
    upd_x = '0;
    upd_y = '0;
    wr_x = '0;
    wr_y = '0;
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    cmp(24'h00_0000, xab_q);
    t_linear();
    t_modulo();
    t_reverse();
    t_multi();
    t_modulo_down();
    t_collide();
    tally_and_finish();
  end
endmodule
